// >>> logic/loop_code_pkg.sv
package loop_code_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_TX_CONTROL  = 8'h74; // Transmit control
  localparam logic [7:0] IDX_TX_PATTERN  = 8'h75; // Transmit code
  localparam logic [7:0] IDX_DET_CONFIG  = 8'h76; // Detector config
  localparam logic [7:0] IDX_DET_STATE   = 8'h77; // Detector status
  localparam logic [7:0] IDX_UP_TARGET   = 8'h78; // Activate code
  localparam logic [7:0] IDX_DOWN_TARGET = 8'h79; // Deactivate code
  localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h7A; // Interrupt enables
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h7B; // Change flags

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TX_EN_BIT     = 3; // Insertion enable
  localparam int TX_UNFM_BIT   = 2; // Unframed insertion
  localparam int TX_CL_LSB     = 0; // Transmit length select
  localparam int CFG_SKIP_BIT  = 4; // Frame bit skip
  localparam int CFG_DSEL_LSB  = 2; // Down length select
  localparam int CFG_ASEL_LSB  = 0; // Up length select
  localparam int UP_BIT        = 1; // Up bit in status, enable, flags
  localparam int DOWN_BIT      = 0; // Down bit in status, enable, flags

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_TX_CONTROL  = 4'h0;
  localparam logic [7:0] RST_TX_PATTERN  = 8'h00;
  localparam logic [4:0] RST_DET_CONFIG  = 5'h04;
  localparam logic [7:0] RST_UP_TARGET   = 8'h08;
  localparam logic [7:0] RST_DOWN_TARGET = 8'h24;

  // ---------------------------------------------------------------
  // Timing and thresholds
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;          // ref_clk period
  localparam int unsigned DET_PERIOD_NS = 39_800_000; // 39.8 ms window
  localparam int unsigned DET_PERIOD_CYC = DET_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          PERIOD_W      = 23;         // Window counter width
  localparam logic [9:0]  ERR_LIMIT     = 10'd600;    // Mismatch limit
  localparam logic [6:0]  GOOD_LIMIT    = 7'd126;     // Good window limit
  localparam int          ADDR_W        = 12;         // APB address width

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid; // Bit strobe
    logic fbit;  // Bit is a frame bit
    logic data;  // Bit value
  } line_bit_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [2:0] phase; // Position in target code
    logic [9:0] errs;  // Mismatches this window
    logic [6:0] good;  // Consecutive good windows
  } det_t;

endpackage : loop_code_pkg

// >>> logic/loop_code_gen_detect.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module loop_code_gen_detect #(
  parameter int unsigned PERIOD_CYCLES = loop_code_pkg::DET_PERIOD_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire loop_code_pkg::apb_req_t apb_req,
  output loop_code_pkg::apb_rsp_t      apb_rsp,
  input  wire loop_code_pkg::line_bit_t tx_in,
  output loop_code_pkg::line_bit_t     tx_out,
  input  wire loop_code_pkg::line_bit_t rx_in,
  output logic                        irq_n
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]                       tx_ctrl;     // Enable, unframed, length
    logic [7:0]                       tx_pat;      // Transmit pattern
    logic [4:0]                       det_cfg;     // Skip, down sel, up sel
    logic [7:0]                       up_tgt;      // Activate target
    logic [7:0]                       down_tgt;    // Deactivate target
    logic [1:0]                       irq_en;      // Interrupt enables
    logic [1:0]                       flags;       // Change flags
    logic [1:0]                       detected;    // Detection status
    logic [2:0]                       tx_phase;    // Transmit code position
    loop_code_pkg::det_t [1:0]        det;         // Per-code detectors
    logic [loop_code_pkg::PERIOD_W-1:0] period_cnt; // Window counter
    logic [31:0]                      prdata;      // Read data
    loop_code_pkg::line_bit_t         tx_bit;      // Outgoing bit
  } state_t;

  state_t q_r;   // Registered state
  state_t q_nxt; // Next state

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Last code position for a length select: 4, 5, 6 or 7
  function automatic logic [2:0] code_last(input logic [1:0] sel);
    code_last = {1'b1, sel};
  endfunction : code_last

  // Code bit at a position, bit 7 first
  function automatic logic code_bit(input logic [7:0] code, input logic [2:0] ph);
    code_bit = code[3'd7 - ph];
  endfunction : code_bit

  // Next position with wrap at the code end
  function automatic logic [2:0] next_phase(input logic [2:0] ph, input logic [2:0] last);
    next_phase = (ph >= last) ? 3'h0 : 3'(ph + 3'h1);
  endfunction : next_phase

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic       addr_hit;   // Address maps to a register
  logic [7:0] addr_idx;   // Register index from address
  logic [7:0] rd_mux;     // Read value before capture
  logic       wr_stb;     // Write takes effect
  logic       rd_setup;   // Read setup cycle
  logic       tx_over;    // This bit is overwritten
  logic       tick;       // Window end
  logic [1:0] mism;       // Counted mismatch per detector
  logic [1:0] cmp_bit;    // Bit is compared
  logic [1:0] loss_now;   // Mismatch limit crossed
  logic [9:0] err_sum [2]; // Updated mismatch counts
  logic [2:0] d_last  [2]; // Detector code end
  logic [7:0] d_tgt   [2]; // Detector target

  // Address decode and read mux
  always_comb begin
    addr_idx = apb_req.paddr[9:2];
    addr_hit = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0) &&
               (addr_idx >= loop_code_pkg::IDX_TX_CONTROL) &&
               (addr_idx <= loop_code_pkg::IDX_IRQ_FLAGS);
    case (addr_idx)
      loop_code_pkg::IDX_TX_CONTROL:  rd_mux = {4'h0, q_r.tx_ctrl};
      loop_code_pkg::IDX_TX_PATTERN:  rd_mux = q_r.tx_pat;
      loop_code_pkg::IDX_DET_CONFIG:  rd_mux = {3'h0, q_r.det_cfg};
      loop_code_pkg::IDX_DET_STATE:   rd_mux = {6'h00, q_r.detected};
      loop_code_pkg::IDX_UP_TARGET:   rd_mux = q_r.up_tgt;
      loop_code_pkg::IDX_DOWN_TARGET: rd_mux = q_r.down_tgt;
      loop_code_pkg::IDX_IRQ_ENABLE:  rd_mux = {6'h00, q_r.irq_en};
      loop_code_pkg::IDX_IRQ_FLAGS:   rd_mux = {6'h00, q_r.flags};
      default:                        rd_mux = 8'h00;
    endcase
    wr_stb   = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_hit;
    rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  end

  // Zero-wait slave, error on unmapped address
  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;
    apb_rsp.prdata  = q_r.prdata;
  end

  // Detector per-bit decode
  always_comb begin
    tick = (q_r.period_cnt >= loop_code_pkg::PERIOD_W'(PERIOD_CYCLES - 1));
    d_tgt[1]  = q_r.up_tgt;
    d_tgt[0]  = q_r.down_tgt;
    d_last[1] = code_last(q_r.det_cfg[loop_code_pkg::CFG_ASEL_LSB +: 2]);
    d_last[0] = code_last(q_r.det_cfg[loop_code_pkg::CFG_DSEL_LSB +: 2]);
    for (int i = 0; i < 2; i++) begin
      // Skipped frame bits do not advance the code position
      cmp_bit[i] = rx_in.valid &&
                   !(rx_in.fbit && q_r.det_cfg[loop_code_pkg::CFG_SKIP_BIT]);
      // Compared frame bits have their result dropped
      mism[i] = cmp_bit[i] && !rx_in.fbit &&
                (rx_in.data != code_bit(d_tgt[i], q_r.det[i].phase));
      if (mism[i] && (q_r.det[i].errs <= loop_code_pkg::ERR_LIMIT)) begin
        err_sum[i] = 10'(q_r.det[i].errs + 10'h001);
      end else begin
        err_sum[i] = q_r.det[i].errs;
      end
      loss_now[i] = (err_sum[i] > loop_code_pkg::ERR_LIMIT);
    end
  end

  // Transmit overwrite decision
  always_comb begin
    tx_over = q_r.tx_ctrl[loop_code_pkg::TX_EN_BIT] && tx_in.valid &&
              (q_r.tx_ctrl[loop_code_pkg::TX_UNFM_BIT] || !tx_in.fbit);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    // Register writes
    if (wr_stb) begin
      case (addr_idx)
        loop_code_pkg::IDX_TX_CONTROL:  q_nxt.tx_ctrl  = apb_req.pwdata[3:0];
        loop_code_pkg::IDX_TX_PATTERN:  q_nxt.tx_pat   = apb_req.pwdata[7:0];
        loop_code_pkg::IDX_DET_CONFIG:  q_nxt.det_cfg  = apb_req.pwdata[4:0];
        loop_code_pkg::IDX_UP_TARGET:   q_nxt.up_tgt   = apb_req.pwdata[7:0];
        loop_code_pkg::IDX_DOWN_TARGET: q_nxt.down_tgt = apb_req.pwdata[7:0];
        loop_code_pkg::IDX_IRQ_ENABLE:  q_nxt.irq_en   = apb_req.pwdata[1:0];
        loop_code_pkg::IDX_IRQ_FLAGS:   q_nxt.flags    = q_r.flags & ~apb_req.pwdata[1:0];
        default:                        q_nxt.flags    = q_r.flags;
      endcase
    end
    // Read data captured in the setup cycle
    if (rd_setup) begin
      q_nxt.prdata = {24'h000000, rd_mux};
    end
    // Transmit path, registered by one cycle
    q_nxt.tx_bit = tx_in;
    if (tx_over) begin
      q_nxt.tx_bit.data = code_bit(q_r.tx_pat, q_r.tx_phase);
      q_nxt.tx_phase = next_phase(q_r.tx_phase,
                                  code_last(q_r.tx_ctrl[loop_code_pkg::TX_CL_LSB +: 2]));
    end else if (!q_r.tx_ctrl[loop_code_pkg::TX_EN_BIT]) begin
      q_nxt.tx_phase = 3'h0;
    end
    // Window counter
    q_nxt.period_cnt = tick ? '0 : loop_code_pkg::PERIOD_W'(q_r.period_cnt + 1'b1);
    // Detectors
    for (int i = 0; i < 2; i++) begin
      if (cmp_bit[i]) begin
        q_nxt.det[i].phase = next_phase(q_r.det[i].phase, d_last[i]);
      end
      q_nxt.det[i].errs = err_sum[i];
      if (loss_now[i]) begin
        q_nxt.detected[i] = 1'b0;
        q_nxt.det[i].good = 7'h00;
      end
      if (tick) begin
        q_nxt.det[i].errs = 10'h000;
        if (err_sum[i] < loop_code_pkg::ERR_LIMIT) begin
          if (q_r.det[i].good <= loop_code_pkg::GOOD_LIMIT) begin
            q_nxt.det[i].good = 7'(q_r.det[i].good + 7'h01);
          end
          if (q_r.det[i].good >= loop_code_pkg::GOOD_LIMIT) begin
            q_nxt.detected[i] = 1'b1;
          end
        end else begin
          q_nxt.det[i].good = 7'h00;
          // Hunt for alignment after a window past the mismatch limit
          if (loss_now[i]) begin
            q_nxt.det[i].phase = next_phase(q_nxt.det[i].phase, d_last[i]);
          end
        end
      end
    end
    // Change flags, set wins over clear
    q_nxt.flags = q_nxt.flags | (q_nxt.detected ^ q_r.detected);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q_r          <= '0;
      q_r.tx_ctrl  <= loop_code_pkg::RST_TX_CONTROL;
      q_r.tx_pat   <= loop_code_pkg::RST_TX_PATTERN;
      q_r.det_cfg  <= loop_code_pkg::RST_DET_CONFIG;
      q_r.up_tgt   <= loop_code_pkg::RST_UP_TARGET;
      q_r.down_tgt <= loop_code_pkg::RST_DOWN_TARGET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Active-low interrupt from enabled, set flags
  always_comb begin
    irq_n  = !(|(q_r.flags & q_r.irq_en));
    tx_out = q_r.tx_bit;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Overwritten bit at code position zero
  sequence s_over_bit;
    tx_over && q_r.tx_phase == 3'h0;
  endsequence

  // Disabled insertion passes every bit unchanged
  a_tx_pass_through: assert property (
    !q_r.tx_ctrl[loop_code_pkg::TX_EN_BIT] |=> tx_out == $past(tx_in))
    else $error("Transmit bit altered while insertion disabled");

  // Framed mode leaves frame bits alone
  a_framed_fbit_kept: assert property (
    tx_in.valid && tx_in.fbit && !q_r.tx_ctrl[loop_code_pkg::TX_UNFM_BIT]
    |=> tx_out.data == $past(tx_in.data))
    else $error("Frame bit changed in framed mode");

  // Unframed mode puts a code bit on frame bits too
  a_unframed_fbit_code: assert property (
    tx_in.valid && tx_in.fbit && q_r.tx_ctrl[loop_code_pkg::TX_EN_BIT] &&
    q_r.tx_ctrl[loop_code_pkg::TX_UNFM_BIT]
    |=> tx_out.data == $past(q_r.tx_pat[3'd7 - q_r.tx_phase]))
    else $error("Frame bit not overwritten in unframed mode");

  // Code position wraps after the selected length
  a_tx_length_wrap: assert property (
    tx_over && $stable(q_r.tx_ctrl) &&
    q_r.tx_phase == code_last(q_r.tx_ctrl[loop_code_pkg::TX_CL_LSB +: 2])
    |=> q_r.tx_phase == 3'h0)
    else $error("Transmit code did not wrap at selected length");

  // Code position steps by one inside the code
  a_tx_phase_step: assert property (
    tx_over && q_r.tx_phase != code_last(q_r.tx_ctrl[loop_code_pkg::TX_CL_LSB +: 2])
    |=> q_r.tx_phase == 3'($past(q_r.tx_phase) + 3'h1))
    else $error("Transmit code position did not step");

  // First code bit is pattern bit seven
  a_tx_msb_first: assert property (
    s_over_bit |=> tx_out.data == $past(q_r.tx_pat[7]))
    else $error("Code start is not bit seven");

  // Frame bits never count as mismatches
  a_fbit_no_error: assert property (
    rx_in.fbit |-> mism == 2'h0)
    else $error("Frame bit counted as mismatch");

  // Skipped frame bits hold the code position
  a_skip_holds_phase: assert property (
    rx_in.valid && rx_in.fbit && q_r.det_cfg[loop_code_pkg::CFG_SKIP_BIT] && !tick
    |=> $stable(q_r.det[1].phase) && $stable(q_r.det[0].phase))
    else $error("Skipped frame bit moved the code position");

  // Up code position wraps at its length
  a_up_phase_wrap: assert property (
    cmp_bit[1] && !tick && q_r.det[1].phase == d_last[1] |=> q_r.det[1].phase == 3'h0)
    else $error("Up code position did not wrap");

  // Down code position wraps at its length
  a_down_phase_wrap: assert property (
    cmp_bit[0] && !tick && q_r.det[0].phase == d_last[0] |=> q_r.det[0].phase == 3'h0)
    else $error("Down code position did not wrap");

  // Up code starts at target bit seven
  a_up_first_bit: assert property (
    cmp_bit[1] && !rx_in.fbit && q_r.det[1].phase == 3'h0 && rx_in.data != q_r.up_tgt[7]
    |-> mism[1])
    else $error("Up code start mismatch not counted");

  // Down code starts at target bit seven
  a_down_first_bit: assert property (
    cmp_bit[0] && !rx_in.fbit && q_r.det[0].phase == 3'h0 && rx_in.data != q_r.down_tgt[7]
    |-> mism[0])
    else $error("Down code start mismatch not counted");

  // Mismatch count restarts each window
  a_window_restart: assert property (
    tick |=> q_r.det[1].errs == 10'h000 && q_r.det[0].errs == 10'h000)
    else $error("Mismatch count kept across window end");

  // Mismatch past the limit drops up detection
  a_up_loss: assert property (
    mism[1] && q_r.det[1].errs == loop_code_pkg::ERR_LIMIT |=> !q_r.detected[1])
    else $error("Up detection kept past mismatch limit");

  // Mismatch past the limit drops down detection
  a_down_loss: assert property (
    mism[0] && q_r.det[0].errs == loop_code_pkg::ERR_LIMIT |=> !q_r.detected[0])
    else $error("Down detection kept past mismatch limit");

  // Up detection only after enough good windows
  a_up_set_cause: assert property (
    $rose(q_r.detected[1]) |-> $past(q_r.det[1].good) >= loop_code_pkg::GOOD_LIMIT)
    else $error("Up detection set too early");

  // Down detection only after enough good windows
  a_down_set_cause: assert property (
    $rose(q_r.detected[0]) |-> $past(q_r.det[0].good) >= loop_code_pkg::GOOD_LIMIT)
    else $error("Down detection set too early");

  // A status change raises the flag of at least one changed bit
  a_change_flags: assert property (
    q_r.detected != $past(q_r.detected)
    |-> |(q_r.flags & (q_r.detected ^ $past(q_r.detected))))
    else $error("Detection change did not raise its flag");

  // Clear up flag stays clear without a change
  a_flag_no_spurious: assert property (
    !q_r.flags[1] && q_nxt.detected[1] == q_r.detected[1] |=> !q_r.flags[1])
    else $error("Up change flag set without a change");

  // Write of one clears the up flag
  a_flag_w1c: assert property (
    wr_stb && addr_idx == loop_code_pkg::IDX_IRQ_FLAGS && apb_req.pwdata[1] &&
    q_nxt.detected[1] == q_r.detected[1] |=> !q_r.flags[1])
    else $error("Up change flag not cleared by write of one");

  // Write of one clears the down flag
  a_down_flag_w1c: assert property (
    wr_stb && addr_idx == loop_code_pkg::IDX_IRQ_FLAGS && apb_req.pwdata[0] &&
    q_nxt.detected[0] == q_r.detected[0] |=> !q_r.flags[0])
    else $error("Down change flag not cleared by write of one");

  // Interrupt pin follows enabled, set flags
  a_irq_level: assert property (
    irq_n == !((q_r.flags[1] && q_r.irq_en[1]) || (q_r.flags[0] && q_r.irq_en[0])))
    else $error("Interrupt level does not match enabled flags");

endmodule : loop_code_gen_detect
`default_nettype wire

// >>> bench/line_partner.sv
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------
// Remote line equipment sending a repeating loop code
// -----------------------------------------------------------------
module line_partner (
  input  wire logic                ref_clk,
  input  wire logic                run,
  input  wire logic                invert,
  input  wire logic [7:0]          code,
  input  wire logic [2:0]          len,
  output loop_code_pkg::line_bit_t rx
);
  logic [2:0] ph_r;  // Position in code
  logic [7:0] cnt_r; // Position in 193-bit frame

  // Known start state
  initial begin
    ph_r = 3'h0;
    cnt_r = 8'h00;
    rx = '0;
  end

  // One bit per clock, F-bit first in each frame
  always @(posedge ref_clk) begin
    if (run) begin
      rx.valid <= 1'h1;
      rx.fbit  <= (cnt_r == 8'h00);
      if (cnt_r == 8'h00) begin
        rx.data <= ~code[3'h7 - ph_r]; // F-bit wrong, takes no code slot
      end else begin
        rx.data <= code[3'h7 - ph_r] ^ invert;
        ph_r    <= (ph_r == len - 3'h1) ? 3'h0 : ph_r + 3'h1;
      end
      cnt_r <= (cnt_r == 8'hC0) ? 8'h00 : cnt_r + 8'h01;
    end else begin
      rx.valid <= 1'h0;
      rx.fbit  <= 1'h0;
      rx.data  <= ~rx.data; // Idle line keeps toggling
    end
  end
endmodule : line_partner
`default_nettype wire

// >>> bench/loop_code_gen_detect_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module loop_code_gen_detect_tb_top;
  // ---------------------------------------------------------------
  // Setup
  // ---------------------------------------------------------------
  localparam int unsigned PER  = 700;   // Shortened detection window
  localparam logic [7:0]  CODE = 8'hA8; // Five-bit code 10101

  typedef struct packed {
    logic [7:0]  ctrl; // Transmit control
    logic [7:0]  pat;  // Transmit pattern
    logic [11:0] exp;  // Expected data, bit n is the n-th bit
  } tx_row_t;

  logic                      ref_clk;
  logic                      nrst;
  loop_code_pkg::apb_req_t   apb_req;
  loop_code_pkg::apb_rsp_t   apb_rsp;
  loop_code_pkg::line_bit_t  tx_in;
  loop_code_pkg::line_bit_t  tx_out;
  loop_code_pkg::line_bit_t  rx_in;
  logic                      irq_n;
  logic                      run;
  logic                      invert;
  logic                      fb;
  logic                      err;
  logic [31:0]               rd;
  int                        fails;
  int                        check_count;
  int                        i;
  int                        j;
  logic [7:0]                rst_exp [8] = '{8'h00, 8'h00, 8'h04, 8'h00,
                                             8'h08, 8'h24, 8'h00, 8'h00};
  tx_row_t                   rows [7] = '{
    '{8'h00, 8'hFF, 12'h208},  // Disabled
    '{8'h08, 8'hA8, 12'hB6D},  // Framed, 5 bits
    '{8'h09, 8'h84, 12'h2C9},  // Framed, 6 bits
    '{8'h0A, 8'h02, 12'h288},  // Framed, 7 bits
    '{8'h0B, 8'hC5, 12'hF4B},  // Framed, 8 bits
    '{8'h0C, 8'hA8, 12'h6B5},  // Unframed, 5 bits
    '{8'h04, 8'hFF, 12'h208}}; // Unframed but disabled

  loop_code_gen_detect #(.PERIOD_CYCLES(PER)) i_dut (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp),
    .tx_in   (tx_in),
    .tx_out  (tx_out),
    .rx_in   (rx_in),
    .irq_n   (irq_n)
  );

  line_partner i_partner (
    .ref_clk (ref_clk),
    .run     (run),
    .invert  (invert),
    .code    (CODE),
    .len     (3'h5),
    .rx      (rx_in)
  );

  // 125 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic slverr);
    int n;
    @(posedge ref_clk);
    apb_req.psel    <= 1'h1;
    apb_req.penable <= 1'h0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= {2'h0, idx, 2'h0};
    apb_req.pwdata  <= wd;
    @(posedge ref_clk);
    apb_req.penable <= 1'h1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (apb_rsp.pready === 1'h1) break;
    end
    if (n == 16) begin
      fails++;
      final_report();
    end
    rdat = apb_rsp.prdata;
    slverr = apb_rsp.pslverr;
    apb_req.psel    <= 1'h0;
    apb_req.penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'h1, idx, {24'h0, d}, rd, err);
  endtask : wr

  // Read and compare, no error response expected
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 32'h0, rd, err);
    chk({err, rd}, {1'h0, 24'h0, exp});
  endtask : rdc

  // Bounded wait for an interrupt level
  task automatic wait_irq(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge ref_clk);
      if (irq_n === lvl) break;
    end
    if (n == lim) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, irq_n, lvl);
      final_report();
    end
  endtask : wait_irq

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'h0;
    apb_req = '0;
    tx_in = '0;
    run = 1'h0;
    invert = 1'h0;
    fails = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'h1;
    chk({tx_out, irq_n}, 33'h1);
    // Reset values, unmapped and read-only places
    for (i = 0; i < 8; i++) begin
      rdc(loop_code_pkg::IDX_TX_CONTROL + 8'(i), rst_exp[i]);
    end
    apb(1'h0, 8'h7C, 32'h0, rd, err);
    chk({err, rd}, {1'h1, 32'h0});
    wr(loop_code_pkg::IDX_DET_STATE, 8'hFF);
    rdc(loop_code_pkg::IDX_DET_STATE, 8'h00);
    // Transmit insertion table
    for (i = 0; i < 7; i++) begin
      wr(loop_code_pkg::IDX_TX_CONTROL, 8'h00);
      wr(loop_code_pkg::IDX_TX_PATTERN, rows[i].pat);
      wr(loop_code_pkg::IDX_TX_CONTROL, rows[i].ctrl);
      rdc(loop_code_pkg::IDX_TX_CONTROL, rows[i].ctrl);
      for (j = 0; j < 12; j++) begin
        fb = (j == 3) || (j == 9);
        @(posedge ref_clk);
        tx_in <= '{valid: 1'h1, fbit: fb, data: fb};
        @(posedge ref_clk);
        tx_in.valid <= 1'h0;
        #1;
        chk(tx_out, {1'h1, fb, rows[i].exp[j]});
      end
    end
    // Detection of matching code on both targets
    wr(loop_code_pkg::IDX_DET_CONFIG, 8'h10);
    wr(loop_code_pkg::IDX_UP_TARGET, CODE);
    wr(loop_code_pkg::IDX_DOWN_TARGET, CODE);
    wr(loop_code_pkg::IDX_IRQ_ENABLE, 8'h02);
    @(posedge ref_clk);
    run <= 1'h1;
    repeat (125 * PER) @(posedge ref_clk);
    rdc(loop_code_pkg::IDX_DET_STATE, 8'h00);
    #1 chk(irq_n, 33'h1);
    wait_irq(1'h0, 3 * PER);
    rdc(loop_code_pkg::IDX_DET_STATE, 8'h03);
    rdc(loop_code_pkg::IDX_IRQ_FLAGS, 8'h03);
    // Masking and clearing
    wr(loop_code_pkg::IDX_IRQ_ENABLE, 8'h00);
    #1 chk(irq_n, 33'h1);
    wr(loop_code_pkg::IDX_IRQ_ENABLE, 8'h01);
    #1 chk(irq_n, 33'h0);
    wr(loop_code_pkg::IDX_IRQ_FLAGS, 8'h00);
    rdc(loop_code_pkg::IDX_IRQ_FLAGS, 8'h03);
    wr(loop_code_pkg::IDX_IRQ_FLAGS, 8'h01);
    #1 chk(irq_n, 33'h1);
    rdc(loop_code_pkg::IDX_IRQ_FLAGS, 8'h02);
    wr(loop_code_pkg::IDX_IRQ_ENABLE, 8'h03);
    #1 chk(irq_n, 33'h0);
    wr(loop_code_pkg::IDX_IRQ_FLAGS, 8'h02);
    #1 chk(irq_n, 33'h1);
    // Loss of code after inverted stream
    @(posedge ref_clk);
    invert <= 1'h1;
    repeat (590) @(posedge ref_clk);
    rdc(loop_code_pkg::IDX_DET_STATE, 8'h03);
    wait_irq(1'h0, 2 * PER + 50);
    rdc(loop_code_pkg::IDX_DET_STATE, 8'h00);
    rdc(loop_code_pkg::IDX_IRQ_FLAGS, 8'h03);
    final_report();
  end
endmodule : loop_code_gen_detect_tb_top
`default_nettype wire
